/* File: core/periodic_timer.sv */
// Operation
// - Mode 00 compare; period match clears counter
// - Compare-A match drives pin high, low, toggle
// - Counter and compare values ten bits wide
// - Clear select one: compare-A match clears counter
// - Only compare-A match and run rise change pin level in compare
// - Run rise restores pin initial level
// - Clear select one: no period flag
// - Mode 11 counts like compare, pin unused
// - Mode 10 with action 10 is PWM
// - PWM period from period value, zero 1024
// - Duty at or above period: always active
// - PWM raises compare-A and period flags
// - PWM polarity, invert and force controls
// - PWM counting continues while pin forced
// - PWM ignores clear select bit
// - Mode 10 action 11 is single pulse
// - Run rise or trigger edge starts pulse
// - Compare-A match or software ends pulse
// - Pulse counter zeroed only on run rise
// - Mode 01 capture, source select chooses pin
// - Capture copies counter to compare-A, flags
// - Action field picks edge; 11 disables capture
// - Capture counter free-runs, period match clears
// - Capture mode drives no output pin
`timescale 1ns/1ps
`default_nettype none
`include "ptimer_cfg.svh"

module periodic_timer #(
   parameter int ADDR_W = 5
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // Timer clock tick from the clock selector
   input  wire logic              timer_tick,
   // AXI4-Lite write channels
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Timer pins
   input  wire logic              capture_input_pin,
   input  wire logic              trigger_input_pin,
   output logic                   timer_out,
   output logic                   timer_out_en
);

   if (ADDR_W < 5) begin : g_addr_check
      $error("ADDR_W must be at least 5");
   end

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Register index from byte address; 7 means unmapped
   function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
      if (a == ADDR_W'(`OFF_CTRL)) reg_index = 3'h0;
      else if (a == ADDR_W'(`OFF_COUNT)) reg_index = 3'h1;
      else if (a == ADDR_W'(`OFF_CMPA)) reg_index = 3'h2;
      else if (a == ADDR_W'(`OFF_PERIOD)) reg_index = 3'h3;
      else if (a == ADDR_W'(`OFF_FLAGS)) reg_index = 3'h4;
      else reg_index = 3'h7;
   endfunction

   // Byte-lane merge of a 16-bit slice
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] nw,
                                           input logic [1:0]  strb);
      logic [15:0] m;
      m = {{8{strb[1]}}, {8{strb[0]}}};
      merge16 = (old & ~m) | (nw & m);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic               awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0]         bresp_q, rresp_q;
   logic [31:0]        rdata_q;
   logic [ADDR_W-1:0]  awaddr_q;
   logic [15:0]        wdata_q;
   logic [1:0]         wstrb_q;
   logic               wr_go;
   logic [2:0]         wr_idx;
   logic [15:0]        ctrl_wr;
   logic [1:0]         mode_q, act_q;
   logic               run_q, run_prev_q, clr_sel_q, oc_q, inv_q, src_q;
   ptimer_pkg::count_t cnt_q, cmp_a_q, per_q, cnt_inc;
   logic               flag_a_q, flag_p_q;
   logic               out_lvl_q, timer_out_q, timer_out_en_q;
   ptimer_pkg::op_t    op;
   logic               run_rise, adv, a_hit, p_hit;
   logic               a_ev, p_ev, cnt_clr, cap_ev, pwm_full;
   logic               trig_rise, trig_fall, capi_rise, capi_fall;
   logic               src_rise, src_fall, pin_d, pin_en_d;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   pin_edge_sync u_trig_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pin     (trigger_input_pin),
      .rise    (trig_rise),
      .fall    (trig_fall)
   );

   pin_edge_sync u_capi_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pin     (capture_input_pin),
      .rise    (capi_rise),
      .fall    (capi_fall)
   );

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave

   // Address and data are held until both are in, in either order
   assign wr_go  = ~awready_q & ~wready_q & ~bvalid_q;
   assign wr_idx = reg_index(awaddr_q);

   // Write channels and response
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= `RESP_OKAY;
         awaddr_q  <= '0;
         wdata_q   <= 16'h0000;
         wstrb_q   <= 2'b00;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            awready_q <= 1'b0;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_q) begin
            wready_q <= 1'b0;
            wdata_q  <= s_axi_wdata[15:0];
            wstrb_q  <= s_axi_wstrb[1:0];
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wr_idx == 3'h7) ? `RESP_SLVERR : `RESP_OKAY;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // Read channels; one cycle from address to data
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rresp_q   <= `RESP_OKAY;
         rdata_q   <= 32'h0000_0000;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= `RESP_OKAY;
         rdata_q   <= 32'h0000_0000;
         case (reg_index(s_axi_araddr))
            3'h0: rdata_q[8:0] <= {src_q, inv_q, oc_q, clr_sel_q, run_q,
                                   act_q, mode_q};
            3'h1: rdata_q[9:0] <= cnt_q;
            3'h2: rdata_q[9:0] <= cmp_a_q;
            3'h3: rdata_q[9:0] <= per_q;
            3'h4: rdata_q[1:0] <= {flag_p_q, flag_a_q};
            default: rresp_q <= `RESP_SLVERR;
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register

   assign ctrl_wr = merge16({7'h00, src_q, inv_q, oc_q, clr_sel_q, run_q,
                             act_q, mode_q}, wdata_q, wstrb_q);

   // Mode and option bits; software keeps action at 11 in pulse mode
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_q    <= `MODE_CMP;
         act_q     <= `ACT_NONE;
         clr_sel_q <= 1'b0;
         oc_q      <= 1'b0;
         inv_q     <= 1'b0;
         src_q     <= 1'b0;
      end else if (wr_go && wr_idx == 3'h0) begin
         mode_q    <= ctrl_wr[`CTRL_MODE_HI:`CTRL_MODE_LO];
         act_q     <= ctrl_wr[`CTRL_ACT_HI:`CTRL_ACT_LO];
         clr_sel_q <= ctrl_wr[`CTRL_CLRSEL];
         oc_q      <= ctrl_wr[`CTRL_INIT];
         inv_q     <= ctrl_wr[`CTRL_INV];
         src_q     <= ctrl_wr[`CTRL_SRCSEL];
      end
   end

   // Run bit; hardware start and stop beat a software write
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         run_q      <= 1'b0;
         run_prev_q <= 1'b0;
      end else begin
         run_prev_q <= run_q;
         if (op == ptimer_pkg::OP_PULSE && a_ev) begin
            run_q <= 1'b0;
         end else if (op == ptimer_pkg::OP_PULSE && trig_rise) begin
            run_q <= 1'b1;
         end else if (wr_go && wr_idx == 3'h0) begin
            run_q <= ctrl_wr[`CTRL_RUN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode decode and comparators

   always_comb begin
      case (mode_q)
         `MODE_CMP: op = ptimer_pkg::OP_CMP;
         `MODE_CAP: op = ptimer_pkg::OP_CAP;
         `MODE_WAVE: op = (act_q == `ACT_PULSE) ? ptimer_pkg::OP_PULSE
                                                : ptimer_pkg::OP_PWM;
         default: op = ptimer_pkg::OP_TMR;
      endcase
   end

   assign run_rise = run_q & ~run_prev_q;
   assign cnt_inc  = cnt_q + 10'h001;
   assign adv      = timer_tick & run_q & ~run_rise;
   // A zero period matches at the wrap, giving 1024 clocks
   assign a_hit    = adv & (cnt_inc == cmp_a_q);
   assign p_hit    = adv & (cnt_inc == per_q);
   assign pwm_full = (per_q != 10'h000) && (cmp_a_q >= per_q);

   // Capture edge from the selected pin
   assign src_rise = src_q ? trig_rise : capi_rise;
   assign src_fall = src_q ? trig_fall : capi_fall;
   always_comb begin
      case (act_q)
         `CAP_RISE: cap_ev = src_rise;
         `CAP_FALL: cap_ev = src_fall;
         `CAP_BOTH: cap_ev = src_rise | src_fall;
         default:   cap_ev = 1'b0;
      endcase
      cap_ev = cap_ev & run_q & (op == ptimer_pkg::OP_CAP);
   end

   // Events and counter clear for each mode
   always_comb begin
      a_ev    = 1'b0;
      p_ev    = 1'b0;
      cnt_clr = 1'b0;
      case (op)
         ptimer_pkg::OP_CMP, ptimer_pkg::OP_TMR: begin
            // Zero compare-A value raises no flag
            a_ev = a_hit & (cmp_a_q != 10'h000);
            if (clr_sel_q) begin
               cnt_clr = a_hit;
            end else begin
               cnt_clr = p_hit;
               p_ev    = p_hit;
            end
         end
         ptimer_pkg::OP_PWM: begin
            a_ev    = a_hit;
            p_ev    = p_hit;
            cnt_clr = p_hit;
         end
         ptimer_pkg::OP_PULSE: begin
            a_ev = a_hit;
         end
         default: begin
            a_ev    = cap_ev;
            p_ev    = p_hit;
            cnt_clr = p_hit;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter and compare registers

   // Counter zeroed on run rise, else advances on each tick while running
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q <= `RST_COUNT;
      end else if (run_rise) begin
         cnt_q <= `RST_COUNT;
      end else if (adv) begin
         cnt_q <= cnt_clr ? `RST_COUNT : cnt_inc;
      end
   end

   // Capture overrides a software write in the same cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmp_a_q <= 10'h000;
         per_q   <= 10'h000;
      end else begin
         if (cap_ev) begin
            cmp_a_q <= cnt_q;
         end else if (wr_go && wr_idx == 3'h2) begin
            cmp_a_q <= 10'(merge16({6'h00, cmp_a_q}, wdata_q, wstrb_q));
         end
         if (wr_go && wr_idx == 3'h3) begin
            per_q <= 10'(merge16({6'h00, per_q}, wdata_q, wstrb_q));
         end
      end
   end

   // Sticky flags, write one to clear; a new event wins over the clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flag_a_q <= 1'b0;
         flag_p_q <= 1'b0;
      end else begin
         flag_a_q <= a_ev | (flag_a_q & ~(wr_go && wr_idx == 3'h4 &&
                     wstrb_q[0] && wdata_q[`FLAG_MATCH_A]));
         flag_p_q <= p_ev | (flag_p_q & ~(wr_go && wr_idx == 3'h4 &&
                     wstrb_q[0] && wdata_q[`FLAG_PERIOD]));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output pin

   // Compare-mode level; run rise loads it, otherwise only a compare-A event moves it
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         out_lvl_q <= 1'b0;
      end else if (run_rise) begin
         out_lvl_q <= oc_q;
      end else if (op == ptimer_pkg::OP_CMP && a_ev) begin
         case (act_q)
            `ACT_LOW:    out_lvl_q <= 1'b0;
            `ACT_HIGH:   out_lvl_q <= 1'b1;
            `ACT_TOGGLE: out_lvl_q <= ~out_lvl_q;
            default:     out_lvl_q <= out_lvl_q;
         endcase
      end
   end

   // Pin value per mode; the invert bit applies last
   always_comb begin
      pin_d    = 1'b0;
      pin_en_d = 1'b0;
      case (op)
         ptimer_pkg::OP_CMP: begin
            pin_en_d = 1'b1;
            pin_d    = out_lvl_q ^ inv_q;
         end
         ptimer_pkg::OP_PWM: begin
            pin_en_d = 1'b1;
            // Forcing the pin leaves the counter running
            if (act_q == `ACT_PWM) begin
               pin_d = ((run_q && (pwm_full || cnt_q < cmp_a_q)) ? oc_q
                        : ~oc_q) ^ inv_q;
            end else begin
               pin_d = (act_q == `ACT_LOW) ^ inv_q;
            end
         end
         ptimer_pkg::OP_PULSE: begin
            pin_en_d = 1'b1;
            pin_d    = (run_q ? oc_q : ~oc_q) ^ inv_q;
         end
         default: begin
            pin_en_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         timer_out_q    <= 1'b0;
         timer_out_en_q <= 1'b0;
      end else begin
         timer_out_q    <= pin_d;
         timer_out_en_q <= pin_en_d;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign timer_out     = timer_out_q;
   assign timer_out_en  = timer_out_en_q;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_cnt_hold: assert property (!adv && !run_rise |=> $stable(cnt_q))
      else $error("counter moved without tick");
   a_cnt_step: assert property (adv && !cnt_clr |=>
      cnt_q == $past(cnt_q) + 10'h001)
      else $error("counter did not step by one");
   a_run_start: assert property (run_rise |=>
      cnt_q == 10'h000 && out_lvl_q == $past(oc_q))
      else $error("run rise did not restart counter and level");
   a_no_pflag: assert property ((op == ptimer_pkg::OP_CMP ||
      op == ptimer_pkg::OP_TMR) && clr_sel_q && !flag_p_q |=> !flag_p_q)
      else $error("period flag set under compare-A clear");
   a_cmp_toggle: assert property (op == ptimer_pkg::OP_CMP &&
      a_ev && act_q == `ACT_TOGGLE |=> out_lvl_q != $past(out_lvl_q))
      else $error("toggle on compare-A match missing");
   a_pulse_end: assert property (op == ptimer_pkg::OP_PULSE &&
      a_ev |=> !run_q && flag_a_q)
      else $error("pulse not ended by compare-A match");
   a_cap_copy: assert property (cap_ev |=>
      cmp_a_q == $past(cnt_q) && flag_a_q)
      else $error("capture did not store counter");
   a_cap_none: assert property (act_q == `ACT_TOGGLE |-> !cap_ev)
      else $error("capture with edge select 11");
   a_cap_nopin: assert property (op == ptimer_pkg::OP_CAP |=>
      !timer_out_en)
      else $error("pin driven in capture mode");
   a_pwm_full: assert property (op == ptimer_pkg::OP_PWM &&
      act_q == `ACT_PWM && run_q && pwm_full |=>
      timer_out == $past(oc_q ^ inv_q))
      else $error("full duty not active");

   c_pulse: cover property (op == ptimer_pkg::OP_PULSE && a_ev);
   c_capture: cover property (cap_ev ##[1:40] cap_ev);
   c_pwm_wrap: cover property (op == ptimer_pkg::OP_PWM && p_ev);

endmodule // periodic_timer

`default_nettype wire

/* File: core/pin_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_edge_sync (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Asynchronous pin and its synchronised edges
   input  wire logic pin,
   output logic      rise,
   output logic      fall
);

   logic meta_q;
   logic sync_q;
   logic prev_q;

   // Two flops before any logic looks at the pin
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;

endmodule // pin_edge_sync

`default_nettype wire

/* File: core/ptimer_cfg.svh */
`ifndef PTIMER_CFG_SVH
`define PTIMER_CFG_SVH

// Register byte offsets
`define OFF_CTRL     5'h00
`define OFF_COUNT    5'h04
`define OFF_CMPA     5'h08
`define OFF_PERIOD   5'h0c
`define OFF_FLAGS    5'h10

// Control register field positions
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_ACT_LO  2
`define CTRL_ACT_HI  3
`define CTRL_RUN     4
`define CTRL_CLRSEL  5
`define CTRL_INIT    6
`define CTRL_INV     7
`define CTRL_SRCSEL  8

// Flag register field positions
`define FLAG_MATCH_A 0
`define FLAG_PERIOD  1

// Mode field and output action encodings
`define MODE_CMP     2'b00
`define MODE_CAP     2'b01
`define MODE_WAVE    2'b10
`define MODE_TMR     2'b11
`define ACT_NONE     2'b00
`define ACT_LOW      2'b01
`define ACT_HIGH     2'b10
`define ACT_TOGGLE   2'b11
`define ACT_PWM      2'b10
`define ACT_PULSE    2'b11
`define CAP_RISE     2'b00
`define CAP_FALL     2'b01
`define CAP_BOTH     2'b10

// Reset values and bus answers
`define RST_COUNT    10'h000
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10

`endif

/* File: core/ptimer_pkg.sv */
`default_nettype none

package ptimer_pkg;

   // Ten-bit counter and compare values
   typedef logic [9:0] count_t;

   // Operating mode decoded from mode and output action fields
   typedef enum logic [2:0] {
      OP_CMP,
      OP_CAP,
      OP_PWM,
      OP_PULSE,
      OP_TMR
   } op_t;

endpackage : ptimer_pkg

`default_nettype wire

/* File: testbench/pin_partner.sv */
`timescale 1ns/1ps
`default_nettype none

// Pin sources for capture and trigger, and a load on the timer output
module pin_partner (
   // Clock
   input  wire logic clk_sys,
   // Pins
   output logic      cap_pin,
   output logic      trig_pin,
   input  wire logic timer_out
);
   // Both sources idle low until a scenario moves them
   initial begin
      cap_pin = 1'b0;
      trig_pin = 1'b0;
   end

   // Levels change just after an edge, as a real source would
   task automatic drive(input logic sel, input logic v);
      @(posedge clk_sys);
      if (sel) trig_pin <= v;
      else cap_pin <= v;
   endtask

   // Counts high cycles; whole periods make the phase irrelevant
   task automatic measure(input int n, output int h);
      h = 0;
      repeat (n) begin
         @(posedge clk_sys);
         h += int'(timer_out);
      end
   endtask
endmodule // pin_partner
`default_nettype wire

/* File: testbench/tb_periodic_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ptimer_cfg.svh"

module tb_periodic_timer;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        timer_tick = 1'b1;
   logic [4:0]  awaddr = 5'h00;
   logic        awvalid = 1'b0;
   logic        awready;
   logic [31:0] wdata = 32'h0;
   logic        wvalid = 1'b0;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready = 1'b0;
   logic [4:0]  araddr = 5'h00;
   logic        arvalid = 1'b0;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready = 1'b0;
   wire         cap_pin;
   wire         trig_pin;
   logic        timer_out;
   logic        timer_out_en;
   int          mismatches = 0;
   int          tests_run = 0;
   logic [31:0] rd;
   logic [31:0] m;
   logic [1:0]  rp;
   int          h;

   // 200 MHz system clock
   always #2.5 clk_sys = ~clk_sys;

   periodic_timer uut (
      .clk_sys(clk_sys), .rst(rst), .timer_tick(timer_tick),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .capture_input_pin(cap_pin), .trigger_input_pin(trig_pin),
      .timer_out(timer_out), .timer_out_en(timer_out_en)
   );

   pin_partner pins (.clk_sys(clk_sys), .cap_pin(cap_pin),
      .trig_pin(trig_pin), .timer_out(timer_out));

   ////////////////////////////////////////////////////////////////////
   // Comparison, bus cycles and setup helpers
   task automatic chk(input string nm, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      rp = bresp;
   endtask

   task automatic rdr(input logic [4:0] a);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      rd = rdata;
      rp = rresp;
   endtask

   function automatic logic [31:0] ctl(input int md, a, r, c, i, v, s);
      return {23'h0, s[0], v[0], i[0], c[0], r[0], a[1:0], md[1:0]};
   endfunction

   // Stop first so the final write gives a clean run rise
   task automatic start(input logic [31:0] c, ca, pe);
      wr(`OFF_CTRL, c & ~32'h10);
      wr(`OFF_CMPA, ca);
      wr(`OFF_PERIOD, pe);
      wr(`OFF_FLAGS, 32'h3);
      wr(`OFF_CTRL, c);
   endtask

   ////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      chk("out_en", timer_out_en, 1'b0);
      wr(`OFF_COUNT, 32'h5);
      rdr(`OFF_COUNT);
      chk("count", rd, 32'h0);
      rdr(5'h14);
      chk("rresp", rp, `RESP_SLVERR);
      wr(5'h14, 32'h1);
      chk("bresp", rp, `RESP_SLVERR);
   endtask

   // Every compare action, each after a fresh run rise
   task automatic t_cmp;
      for (int a = 0; a < 4; a++) begin
         start(ctl(`MODE_CMP, a, 1, 0, a == 1, 0, 0), 32'h8, 32'h14);
         repeat (2) @(posedge clk_sys);
         chk("out_init", timer_out, a == 1);
         repeat (13) @(posedge clk_sys);
         chk("out_match", timer_out, a / 2);
      end
      repeat (20) @(posedge clk_sys);
      rdr(`OFF_FLAGS);
      chk("flags", rd, 32'h3);
      start(ctl(`MODE_CMP, `ACT_NONE, 1, 1, 0, 0, 0), 32'h8, 32'h3);
      repeat (40) @(posedge clk_sys);
      rdr(`OFF_FLAGS);
      chk("flags_clr", rd, 32'h1);
      m = 0;
      repeat (8) begin
         rdr(`OFF_COUNT);
         if (rd > m) m = rd;
      end
      chk("count_max", m inside {[3:7]}, 1'b1);
   endtask

   task automatic t_tmr;
      start(ctl(`MODE_TMR, `ACT_HIGH, 1, 0, 1, 0, 0), 32'h8, 32'h14);
      repeat (50) @(posedge clk_sys);
      rdr(`OFF_FLAGS);
      chk("tmr_flags", rd, 32'h3);
      chk("tmr_en", timer_out_en, 1'b0);
      timer_tick <= 1'b0;
      rdr(`OFF_COUNT);
      m = rd;
      rdr(`OFF_COUNT);
      chk("hold", rd, m);
      timer_tick <= 1'b1;
   endtask

   // Duty table: compare, period, action, clear, invert, window, highs
   task automatic t_pwm;
      int t[7][7] = '{'{3, 8, 2, 0, 0, 64, 24}, '{8, 8, 2, 0, 0, 64, 64},
         '{3, 8, 2, 0, 1, 64, 40}, '{3, 8, 2, 1, 0, 64, 24},
         '{256, 0, 2, 0, 0, 2048, 512}, '{3, 8, 0, 0, 0, 64, 0},
         '{3, 8, 1, 0, 0, 64, 64}};
      for (int k = 0; k < 7; k++) begin
         start(ctl(`MODE_WAVE, t[k][2], 1, t[k][3], 1, t[k][4], 0),
            t[k][0], t[k][1]);
         repeat (4) @(posedge clk_sys);
         pins.measure(t[k][5], h);
         chk("pwm_high", h, t[k][6]);
      end
      rdr(`OFF_FLAGS);
      chk("pwm_flags", rd, 32'h3);
      rdr(`OFF_COUNT);
      m = rd;
      rdr(`OFF_COUNT);
      chk("pwm_runs", rd != m, 1'b1);
   endtask

   // Action stays at pulse for the whole mode
   task automatic t_pulse;
      start(ctl(`MODE_WAVE, `ACT_PULSE, 0, 1, 1, 0, 0),
         32'h14, 32'h5);
      pins.drive(1'b1, 1'b1);
      pins.measure(60, h);
      chk("pulse_w", h inside {[19:21]}, 1'b1);
      rdr(`OFF_CTRL);
      chk("pulse_run", rd[4], 1'b0);
      rdr(`OFF_FLAGS);
      chk("pulse_flag", rd[0], 1'b1);
      pins.drive(1'b1, 1'b0);
      start(ctl(`MODE_WAVE, `ACT_PULSE, 1, 0, 1, 0, 0), 32'hc8, 32'h5);
      wr(`OFF_CTRL, ctl(`MODE_WAVE, `ACT_PULSE, 0, 0, 1, 0, 0));
      pins.measure(20, h);
      chk("pulse_stop", h, 0);
   endtask

   // Each edge kind; odd kinds take the trigger pin as source
   task automatic t_cap;
      for (int a = 0; a < 4; a++) begin
         start(ctl(`MODE_CAP, a, 1, 1, 1, 1, a), 32'h0, 32'h0);
         repeat (20) @(posedge clk_sys);
         pins.drive(a[0], 1'b1);
         repeat (8) @(posedge clk_sys);
         rdr(`OFF_FLAGS);
         chk("cap_rise", rd, a == 0 || a == 2);
         if (a == 0) begin
            rdr(`OFF_CMPA);
            chk("cap_val", rd inside {[20:40]}, 1'b1);
         end
         pins.drive(a[0], 1'b0);
         repeat (8) @(posedge clk_sys);
         rdr(`OFF_FLAGS);
         chk("cap_fall", rd, a < 3);
         chk("cap_en", timer_out_en, 1'b0);
      end
      rdr(`OFF_COUNT);
      chk("cap_runs", rd > 0, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Main sequence after a 12-cycle reset
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset;
      t_cmp;
      t_tmr;
      t_pwm;
      t_pulse;
      t_cap;
      results;
   end

   // Whole run needs well under 10000 cycles
   initial begin
      #200000;
      mismatches++;
      results;
   end
endmodule // tb_periodic_timer
`default_nettype wire
